// [ckc_console.sv]
`timescale 1ns/1ps
module ckc_console
   import ckc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [DW-1:0] wb_dat_i,
   output logic [DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire ckc_cpu_s cpu_i,
   output ckc_kc_s kc_o,
   output ckc_ev_s ev_o,
   output logic run_o,
   output logic bootstrap_mode_lamp_o,
   output logic supervisor_mode_o,
   output logic core_route_o,
   output logic inhibit_o
);
   logic [AW-1:0] asw_reg; // address switches
   logic [DW-1:0] dsw_reg; // data switches
   logic [2:0] swr_reg; // hold, wait, instruction stop
   logic [BW-1:0] reloc_reg; // relocation block
   logic [BW-1:0] prot_reg; // highest block number allowed in user mode
   logic [NKEY-1:0] kreq_reg; // keys pressed, not yet taken
   logic [DW-1:0] disp_reg; // memory display
   logic [AW-1:0] rad_reg; // relocated address display
   logic [AW-1:0] last_reg; // address of last key cycle
   logic pic_reg; // interrupt_cycle_flag
   logic sync_x_reg, start_x_reg; // look_here_key lamps
   logic sync_d_reg, start_d_reg; // deposit-this lamps
   logic stop_q_reg; // previous stop key level
   logic [OSW-1:0] os_reg; // one-shot count
   logic crun_reg; // run seen when key taken
   logic [3:0] fn_reg; // key being served
   ckc_state_e state_reg;
   logic wb_req; // new bus request
   logic [DW-1:0] wmask; // byte enable mask
   logic [NKEY-1:0] elig; // keys allowed now
   logic [3:0] pick; // lowest allowed key
   logic stop_edge; // stop key turn-on
   logic user; // full user restrictions apply
   logic [AW-1:0] kaddr; // address for the key cycle
   logic [BW:0] rblk; // relocated block number

   // one-cycle answer to every request
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // expand byte enables to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sel
         assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   // key eligibility and lowest key first
   always_comb begin
      elig = run_o ? (kreq_reg & ~GATED) : kreq_reg;
      pick = 4'h0;
      for (int i = NKEY - 1; i >= 0; i--) begin
         if (elig[i]) begin
            pick = 4'(i);
         end
      end
   end

   assign stop_edge = swr_reg[SW_ISTOP] & ~stop_q_reg;
   assign user = ~supervisor_mode_o & ~pic_reg;

   // key address: deposit and look next follow the last one
   always_comb begin
      kaddr = asw_reg;
      if (fn_reg == 4'(K_XNEXT) || fn_reg == 4'(K_DNEXT)) begin
         kaddr = last_reg + 18'h00001;
      end
      rblk = {1'b0, kaddr[AW-1:BLK_LSB]} + {1'b0, reloc_reg};
   end

   // bus answer and read data
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               ADR_ASW: wb_dat_o <= 32'(asw_reg);
               ADR_DSW: wb_dat_o <= dsw_reg;
               ADR_KEY: wb_dat_o <= 32'(kreq_reg);
               ADR_SWR: wb_dat_o <= 32'(swr_reg);
               ADR_MAP: wb_dat_o <= {16'h0000, reloc_reg, prot_reg};
               ADR_STS: begin
                  wb_dat_o[ST_RUN] <= run_o;
                  wb_dat_o[ST_BOOT] <= bootstrap_mode_lamp_o;
                  wb_dat_o[ST_SUP] <= supervisor_mode_o;
                  wb_dat_o[ST_PIC] <= pic_reg;
                  wb_dat_o[ST_SYX] <= sync_x_reg;
                  wb_dat_o[ST_STX] <= start_x_reg;
                  wb_dat_o[ST_SYD] <= sync_d_reg;
                  wb_dat_o[ST_STD] <= start_d_reg;
                  wb_dat_o[ST_INH] <= inhibit_o;
               end
               ADR_DSP: wb_dat_o <= disp_reg;
               ADR_RAD: wb_dat_o <= 32'(rad_reg);
               default: wb_dat_o <= 32'h00000000; // unmapped reads zero
            endcase
         end
      end
   end

   // switch registers written by software
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         asw_reg <= 18'h00000;
         dsw_reg <= 32'h00000000;
         swr_reg <= 3'h0;
         reloc_reg <= 8'h00;
         prot_reg <= 8'h00;
      end else if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            ADR_ASW: asw_reg <= AW'((32'(asw_reg) & ~wmask) | (wb_dat_i & wmask));
            ADR_DSW: dsw_reg <= (dsw_reg & ~wmask) | (wb_dat_i & wmask);
            ADR_SWR: begin
               if (wb_sel_i[0]) begin
                  swr_reg <= wb_dat_i[2:0];
               end
            end
            ADR_MAP: begin
               if (wb_sel_i[0]) begin
                  prot_reg <= wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  reloc_reg <= wb_dat_i[15:8];
               end
            end
            default: ; // other writes ignored
         endcase
      end
   end

   // pressed keys wait until the sequencer takes or drops them
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         kreq_reg <= 10'h000;
      end else begin
         if (state_reg == S_IDLE) begin
            kreq_reg <= 10'h000; // gated keys are lost, as on the panel
         end
         if (wb_req && wb_we_i && wb_adr_i == ADR_KEY) begin
            kreq_reg <= NKEY'(wb_dat_i & wmask);
         end
      end
   end

   // key sequencer
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_reg <= S_IDLE;
         fn_reg <= 4'h0;
         crun_reg <= 1'b0;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (elig != 10'h000) begin
                  fn_reg <= pick;
                  crun_reg <= run_o;
                  if (run_o) begin
                     state_reg <= S_WAIT;
                  end else begin
                     state_reg <= S_CYC;
                  end
               end
            end
            S_WAIT: begin
               if (!run_o) begin
                  state_reg <= S_IDLE; // halted first: not done
               end else if (cpu_i.boundary) begin
                  state_reg <= S_CYC;
               end
            end
            S_CYC: state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // key cycle output, display and protection check
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         kc_o <= '0;
         disp_reg <= 32'h00000000;
         rad_reg <= 18'h00000;
         last_reg <= 18'h00000;
         ev_o.illegal_addr <= 1'b0;
      end else begin
         kc_o.go <= 1'b0;
         ev_o.illegal_addr <= 1'b0;
         if (state_reg == S_CYC) begin
            kc_o.go <= 1'b1;
            kc_o.fn <= fn_reg;
            kc_o.data <= dsw_reg;
            kc_o.pi_insn <= (fn_reg == 4'(K_EXEC)) & cpu_i.pi_req;
            last_reg <= kaddr;
            kc_o.addr <= kaddr;
            rad_reg <= kaddr;
            if (!crun_reg && user && kaddr > FAST_TOP) begin
               kc_o.addr <= {rblk[BW-1:0], kaddr[BLK_LSB-1:0]};
               rad_reg <= {rblk[BW-1:0], kaddr[BLK_LSB-1:0]};
            end
            if (!crun_reg && user && kaddr[AW-1:BLK_LSB] > prot_reg) begin
               ev_o.illegal_addr <= 1'b1;
            end
            if (fn_reg == 4'(K_DTHIS) || fn_reg == 4'(K_DNEXT)) begin
               disp_reg <= dsw_reg;
            end
         end
      end
   end

   // handshake lamp pairs for look-here and deposit-this
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sync_x_reg <= 1'b0;
         start_x_reg <= 1'b0;
         sync_d_reg <= 1'b0;
         start_d_reg <= 1'b0;
      end else if (state_reg == S_IDLE && elig != 10'h000) begin
         if (pick == 4'(K_XTHIS)) begin
            sync_x_reg <= 1'b1;
            start_x_reg <= 1'b1;
         end
         if (pick == 4'(K_DTHIS)) begin
            sync_d_reg <= 1'b1;
            start_d_reg <= 1'b1;
         end
      end else if (state_reg == S_CYC) begin
         if (fn_reg == 4'(K_XTHIS)) begin
            start_x_reg <= 1'b0;
            sync_x_reg <= sync_x_reg & ~crun_reg;
         end
         if (fn_reg == 4'(K_DTHIS)) begin
            start_d_reg <= 1'b0;
            sync_d_reg <= sync_d_reg & ~crun_reg;
         end
      end
   end

   // bootstrap mode and its lamp
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         bootstrap_mode_lamp_o <= 1'b0;
      end else if (state_reg == S_CYC && fn_reg == 4'(K_READIN)) begin
         bootstrap_mode_lamp_o <= 1'b1; // readin lights the lamp even with the hold switch up
      end else if (swr_reg[SW_HOLD]) begin
         bootstrap_mode_lamp_o <= bootstrap_mode_lamp_o;
      end else if (cpu_i.fetch && cpu_i.fetch_addr > FAST_TOP) begin
         bootstrap_mode_lamp_o <= 1'b0;
      end else if (state_reg == S_CYC && fn_reg != 4'(K_ICONT) && fn_reg != 4'(K_MCONT)) begin
         bootstrap_mode_lamp_o <= 1'b0;
      end
   end

   // low addresses go to core during bootstrap
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         core_route_o <= 1'b0;
      end else begin
         core_route_o <= bootstrap_mode_lamp_o & (cpu_i.mem_addr <= FAST_TOP);
      end
   end

   // processor-active flag; any clear beats a start
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         run_o <= 1'b0;
      end else if (cpu_i.halt_exec || stop_edge) begin
         run_o <= 1'b0;
      end else if (state_reg == S_CYC && (fn_reg == 4'(K_READIN) || fn_reg == 4'(K_START)
                   || fn_reg == 4'(K_ICONT) || fn_reg == 4'(K_MCONT))) begin
         run_o <= 1'b1;
      end
   end

   // emergency stop one-shot
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         stop_q_reg <= 1'b0;
         os_reg <= 8'h00;
         inhibit_o <= 1'b0;
      end else begin
         stop_q_reg <= swr_reg[SW_ISTOP];
         if (stop_edge) begin
            os_reg <= OSW'(ONESHOT_CYC);
            inhibit_o <= 1'b1;
         end else if (os_reg != 8'h00) begin
            os_reg <= os_reg - 8'h01;
            inhibit_o <= (os_reg != 8'h01);
         end
      end
   end

   // supervisor mode
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         supervisor_mode_o <= 1'b1;
      end else if (state_reg == S_CYC && fn_reg == 4'(K_IORST)) begin
         supervisor_mode_o <= 1'b1;
      end else if (cpu_i.con_done && !supervisor_mode_o && !pic_reg && cpu_i.illegal) begin
         supervisor_mode_o <= 1'b1;
      end else if (cpu_i.con_done && !supervisor_mode_o && pic_reg
                   && (cpu_i.trap || (cpu_i.illegal && !cpu_i.inout_transfer_instruction))) begin
         supervisor_mode_o <= 1'b1;
      end else if (cpu_i.user_enter) begin
         supervisor_mode_o <= 1'b0;
      end
   end

   // interrupt cycle flag and break handling; entry wins
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pic_reg <= 1'b0;
         ev_o.break_hold <= 1'b0;
         ev_o.repeat_insn <= 1'b0;
      end else begin
         ev_o.break_hold <= 1'b0;
         ev_o.repeat_insn <= 1'b0;
         if (pic_reg && cpu_i.con_done && !cpu_i.inout_transfer_instruction) begin
            pic_reg <= 1'b0;
            ev_o.break_hold <= 1'b1;
         end else if (pic_reg && cpu_i.pi_done) begin
            if (cpu_i.cond_iot) begin
               ev_o.repeat_insn <= 1'b1;
            end else begin
               pic_reg <= 1'b0;
               ev_o.break_hold <= 1'b1;
            end
         end
         if (cpu_i.pi_enter) begin
            pic_reg <= 1'b1;
         end
      end
   end

   // in-out clear and absent-bank trap pulses
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ev_o.io_clear <= 1'b0;
         ev_o.trap <= 1'b0;
      end else begin
         ev_o.io_clear <= (state_reg == S_CYC) && (fn_reg == 4'(K_IORST));
         ev_o.trap <= cpu_i.fetch & cpu_i.absent & ~swr_reg[SW_WAIT];
      end
   end

   route_core_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      bootstrap_mode_lamp_o && cpu_i.mem_addr <= FAST_TOP |=> core_route_o)
      else $error("low address not routed to core");
   leave_boot_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      cpu_i.fetch && cpu_i.fetch_addr > FAST_TOP && !swr_reg[SW_HOLD] && state_reg != S_CYC
      |=> !bootstrap_mode_lamp_o)
      else $error("bootstrap kept after high fetch");
   hold_boot_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      swr_reg[SW_HOLD] && bootstrap_mode_lamp_o |=> bootstrap_mode_lamp_o)
      else $error("bootstrap lost under hold");
   gate_run_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      kc_o.go && $past(crun_reg) |-> !GATED[kc_o.fn])
      else $error("gated key ran while active");
   halt_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      cpu_i.halt_exec |=> !run_o)
      else $error("halt left run set");
   stop_edge_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      stop_edge |=> inhibit_o && !run_o ##1 inhibit_o [*3])
      else $error("stop key did not inhibit");
   held_stop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      $rose(inhibit_o) |-> $past(stop_edge))
      else $error("inhibit without stop turn-on");
   lamp_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      state_reg == S_CYC && fn_reg == 4'(K_XTHIS) && !crun_reg |=> sync_x_reg && !start_x_reg)
      else $error("sync lamp cleared while stopped");
   trap_absent_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      cpu_i.fetch && cpu_i.absent && !swr_reg[SW_WAIT] |=> ev_o.trap)
      else $error("absent fetch not trapped");
endmodule

// [ckc_pkg.sv]
package ckc_pkg;
   // bus geometry
   localparam int AW = 18; // machine address width
   localparam int DW = 32; // bus data width
   // register byte offsets
   localparam logic [7:0] ADR_ASW = 8'h00; // address switches
   localparam logic [7:0] ADR_DSW = 8'h04; // data switches
   localparam logic [7:0] ADR_KEY = 8'h08; // key presses, write one
   localparam logic [7:0] ADR_SWR = 8'h0c; // toggle switches
   localparam logic [7:0] ADR_MAP = 8'h10; // relocation and protection
   localparam logic [7:0] ADR_STS = 8'h14; // status lamps
   localparam logic [7:0] ADR_DSP = 8'h18; // memory display word
   localparam logic [7:0] ADR_RAD = 8'h1c; // relocated address display
   // key numbers in the key register
   localparam int NKEY = 10;
   localparam int K_READIN = 0;
   localparam int K_START = 1;
   localparam int K_ICONT = 2;
   localparam int K_MCONT = 3;
   localparam int K_XTHIS = 4;
   localparam int K_XNEXT = 5;
   localparam int K_DTHIS = 6;
   localparam int K_DNEXT = 7;
   localparam int K_EXEC = 8;
   localparam int K_IORST = 9;
   // keys blocked while the processor is active
   localparam logic [NKEY-1:0] GATED = 10'h3a7;
   // switch bits
   localparam int SW_HOLD = 0;
   localparam int SW_WAIT = 1;
   localparam int SW_ISTOP = 2;
   // status bits
   localparam int ST_RUN = 0;
   localparam int ST_BOOT = 1;
   localparam int ST_SUP = 2;
   localparam int ST_PIC = 3;
   localparam int ST_SYX = 4;
   localparam int ST_STX = 5;
   localparam int ST_SYD = 6;
   localparam int ST_STD = 7;
   localparam int ST_INH = 8;
   // fast memory occupies 0 to 17 octal
   localparam logic [AW-1:0] FAST_TOP = 18'h0000f;
   // protection and relocation work in blocks of 1024 words
   localparam int BLK_LSB = 10;
   localparam int BW = AW - BLK_LSB;
   // emergency stop one-shot
   localparam int CLK_NS = 10;
   localparam int ONESHOT_NS = 1000;
   localparam int ONESHOT_CYC = (ONESHOT_NS + CLK_NS - 1) / CLK_NS;
   localparam int OSW = 8;
   // processor-side events, all on mclk_i
   typedef struct packed {
      logic fetch;
      logic [AW-1:0] fetch_addr;
      logic absent;
      logic halt_exec;
      logic boundary;
      logic con_done;
      logic illegal;
      logic trap;
      logic inout_transfer_instruction;
      logic cond_iot;
      logic pi_req;
      logic pi_enter;
      logic pi_done;
      logic user_enter;
      logic [AW-1:0] mem_addr;
   } ckc_cpu_s;
   // key cycle request to the main sequence
   typedef struct packed {
      logic go;
      logic [3:0] fn;
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
      logic pi_insn;
   } ckc_kc_s;
   // one-cycle event pulses
   typedef struct packed {
      logic illegal_addr;
      logic io_clear;
      logic break_hold;
      logic repeat_insn;
      logic trap;
   } ckc_ev_s;
   // key sequencer states
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_WAIT = 3'b010,
      S_CYC = 3'b100
   } ckc_state_e;
endpackage

// [ckc_partner.sv]
`timescale 1ns/1ps
// processor time chain as seen by the console block
module ckc_partner
   import ckc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire ckc_kc_s kc_i,
   input wire ckc_cpu_s drv_i,
   output ckc_cpu_s cpu_o
);
   logic [1:0] phase_reg; // instruction phase, boundary every fourth cycle
   logic done_reg; // console instruction finishing
   // free-running phase and console execute completion
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         phase_reg <= 2'h0;
         done_reg <= 1'b0;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         done_reg <= kc_i.go && (kc_i.fn == 4'(K_EXEC));
      end
   end
   // bench events merged with the chain's own pulses
   always_comb begin
      cpu_o = drv_i;
      cpu_o.boundary = drv_i.boundary | (run_i && phase_reg == 2'h0);
      cpu_o.con_done = drv_i.con_done | done_reg;
      cpu_o.mem_addr = kc_i.addr;
   end
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
   import ckc_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [DW-1:0] dat = 32'h0;
   logic [DW-1:0] q;
   logic [DW-1:0] rdat;
   logic ack, run, boot, sup, core, inh;
   ckc_cpu_s ctl = '0; // pulses from the bench
   ckc_cpu_s lvl = '0; // levels from the bench
   ckc_cpu_s cpu;
   ckc_kc_s kc, lk;
   ckc_ev_s ev;
   ckc_ev_s evs = '0; // sticky record of event pulses
   int n_fail = 0;
   int compares = 0;
   int gos = 0;
   int inh_n = 0;
   always #5 mclk_i = ~mclk_i;
   ckc_console i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_i(cpu),
      .kc_o(kc), .ev_o(ev), .run_o(run), .bootstrap_mode_lamp_o(boot), .supervisor_mode_o(sup),
      .core_route_o(core), .inhibit_o(inh));
   ckc_partner i_far (.mclk_i(mclk_i), .reset_i(reset_i), .run_i(run), .kc_i(kc),
      .drv_i(ckc_cpu_s'(ctl | lvl)), .cpu_o(cpu));
   // record design pulses where they are settled
   always @(negedge mclk_i) begin
      if (kc.go === 1'b1) begin
         gos++;
         lk = kc;
      end
      evs = ckc_ev_s'(evs | ev);
      if (inh === 1'b1) inh_n++;
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one classic wishbone cycle, held until ack
   task wb(input logic w, input logic [7:0] a, input logic [DW-1:0] d);
      int i;
      i = 0;
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge mclk_i);
         i++;
      end while (ack !== 1'b1 && i < 20);
      if (ack !== 1'b1) n_fail++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask
   task key(input int k);
      wb(1'b1, ADR_KEY, 32'h1 << k);
   endtask
   task idle(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // bounded wait for the next key cycle
   task await_go;
      int k;
      int i;
      k = gos;
      i = 0;
      while (gos == k && i < 100) begin
         @(negedge mclk_i);
         i++;
      end
      chk("go", gos, k + 1);
      idle(2);
   endtask
   // one-cycle processor event
   task pulse(input int f, input logic [AW-1:0] a);
      ckc_cpu_s v;
      v = '0;
      v.fetch_addr = a;
      case (f)
         0: v.fetch = 1'b1;
         1: v.halt_exec = 1'b1;
         2: v.user_enter = 1'b1;
         3: v.pi_enter = 1'b1;
         4: v.pi_done = 1'b1;
         default: begin
            v.fetch = 1'b1;
            v.absent = 1'b1;
         end
      endcase
      @(posedge mclk_i);
      ctl <= v;
      @(posedge mclk_i);
      ctl <= '0;
      idle(2);
   endtask
   task complete_run;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      idle(30000);
      n_fail++;
      complete_run;
   end
   initial begin
      int g;
      idle(4);
      reset_i <= 1'b0;
      rd(ADR_STS, 32'h4, "sts reset");
      rd(8'h40, 32'h0, "unmapped");
      wb(1'b1, ADR_ASW, 32'h5);
      wb(1'b1, ADR_DSW, 32'h1234);
      key(K_DTHIS);
      await_go;
      chk("addr", lk.addr, 32'h5);
      chk("data", lk.data, 32'h1234);
      rd(ADR_DSP, 32'h1234, "display");
      rd(ADR_STS, 32'h44, "lamps stopped");
      wb(1'b1, ADR_DSW, 32'h5678);
      key(K_DNEXT);
      await_go;
      chk("next addr", lk.addr, 32'h6);
      rd(ADR_DSP, 32'h5678, "display");
      key(K_READIN);
      await_go;
      chk("core", core, 1'b1);
      g = gos;
      key(K_START);
      idle(10);
      chk("gated", gos, g);
      pulse(0, 18'h10);
      chk("boot", boot, 1'b0);
      key(K_XTHIS);
      await_go;
      chk("fn", lk.fn, 32'h4);
      chk("still running", run, 1'b1);
      rd(ADR_STS, 32'h45, "lamps running");
      pulse(1, 18'h0);
      chk("run", run, 1'b0);
      key(K_READIN);
      await_go;
      pulse(1, 18'h0);
      key(K_ICONT);
      await_go;
      chk("boot", boot, 1'b1);
      pulse(1, 18'h0);
      key(K_XNEXT);
      await_go;
      chk("boot", boot, 1'b0);
      wb(1'b1, ADR_SWR, 32'h1);
      key(K_READIN);
      await_go;
      pulse(1, 18'h0);
      key(K_XNEXT);
      await_go;
      chk("boot", boot, 1'b1);
      wb(1'b1, ADR_SWR, 32'h0);
      key(K_START);
      await_go;
      wb(1'b1, ADR_SWR, 32'h4);
      idle(1);
      chk("run", run, 1'b0);
      idle(120);
      chk("inhibit", inh_n, ONESHOT_CYC);
      key(K_START);
      await_go;
      wb(1'b1, ADR_SWR, 32'h4);
      idle(5);
      chk("run", run, 1'b1);
      chk("inhibit", inh_n, ONESHOT_CYC);
      wb(1'b1, ADR_SWR, 32'h0);
      pulse(1, 18'h0);
      pulse(2, 18'h0);
      wb(1'b1, ADR_MAP, 32'h0401);
      wb(1'b1, ADR_ASW, 32'h0405);
      key(K_XTHIS);
      await_go;
      chk("reloc", lk.addr, 32'h1405);
      rd(ADR_RAD, 32'h1405, "reloc display");
      wb(1'b1, ADR_ASW, 32'h0c00);
      evs = '0;
      key(K_XTHIS);
      idle(10);
      chk("illegal", evs.illegal_addr, 1'b1);
      wb(1'b1, ADR_ASW, 32'h0405);
      key(K_START);
      await_go;
      key(K_XTHIS);
      await_go;
      chk("unmapped run", lk.addr, 32'h0405);
      pulse(1, 18'h0);
      lvl.illegal <= 1'b1;
      key(K_EXEC);
      idle(10);
      chk("sup", sup, 1'b1);
      lvl.illegal <= 1'b0;
      lvl.pi_req <= 1'b1;
      key(K_EXEC);
      await_go;
      chk("pi insn", lk.pi_insn, 1'b1);
      lvl.pi_req <= 1'b0;
      pulse(2, 18'h0);
      evs = '0;
      key(K_IORST);
      await_go;
      chk("io clear", evs.io_clear, 1'b1);
      chk("sup", sup, 1'b1);
      pulse(3, 18'h0);
      evs = '0;
      key(K_EXEC);
      idle(10);
      chk("break", evs.break_hold, 1'b1);
      wb(1'b0, ADR_STS, 32'h0);
      chk("pi flag", q[ST_PIC], 1'b0);
      pulse(2, 18'h0);
      pulse(3, 18'h0);
      key(K_XTHIS);
      await_go;
      chk("pi unmapped", lk.addr, 32'h0405);
      evs = '0;
      lvl.cond_iot <= 1'b1;
      pulse(4, 18'h0);
      chk("repeat", evs.repeat_insn, 1'b1);
      chk("no progress", evs.break_hold, 1'b0);
      lvl.cond_iot <= 1'b0;
      evs = '0;
      pulse(5, 18'h20);
      chk("trap", evs.trap, 1'b1);
      complete_run;
   end
endmodule
